// file: ctap_pkg.sv
// constants for the cache test access port: register map, fields, codes
// assumes a 32-bit register port with byte addresses on word boundaries
package ctap_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LINE_W = 128;
  localparam int unsigned NUM_LINES = 256;
  localparam int unsigned NUM_SETS = 4;
  localparam int unsigned NUM_ENTRIES = NUM_LINES * NUM_SETS;
  localparam int unsigned ENTRY_W = 10;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] DATA_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] TAG_IDX = 8'h04;
  localparam logic [ADDR_W-1:0] CTL_IDX = 8'h05;
  localparam logic [ADDR_W-1:0] DATA_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] TAG_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] CTL_ADDR = 8'h14;

  // control register fields
  localparam int unsigned CTL_CODE_LSB = 0;
  localparam int unsigned CTL_SEL_LSB = 2;
  localparam int unsigned CTL_LINE_LSB = 4;
  localparam int unsigned CTL_W = 12;

  // tag register fields
  localparam int unsigned TAG_ADDR_LSB = 12;
  localparam int unsigned TAG_ADDR_W = 20;
  localparam int unsigned TAG_VALID_BIT = 10;
  localparam int unsigned TAG_LRU_LSB = 7;
  localparam int unsigned TAG_DIRTY_LSB = 3;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [LINE_W-1:0] RESET_LINE = 128'h0;
  localparam logic [2:0] LRU_RESET = 3'h0;
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;

  typedef enum logic [1:0] {
    CODE_BUFFER = 2'h0,
    CODE_CACHE_WRITE = 2'h1,
    CODE_CACHE_READ = 2'h2,
    CODE_CACHE_FLUSH = 2'h3
  } ctap_code_type;
endpackage

// file: ctap_top.sv
// cache test access port: fill/flush buffers, test registers and the cache arrays
// assumes a single-cycle strobe register port; read data one cycle after the strobe
//
// Summary of operation
// - five operations: flush read, fill, write, read, flush
// - code 01 copies fill buffer into line
// - cache write takes tag, valid, dirty from tag
// - code 10 copies selected line to flush
// - after read, tag register shows entry state
// - data read returns selected flush buffer word
// - data write loads selected fill buffer word while control code is 00
// - code 11 clears every valid bit
// - control bits 11:4 pick one line
// - control bits 3:2 pick set or word
// - tag register field layout, reserved bits zero
// - pseudo-lru field, ignored by tag register writes
`timescale 1ns/1ps
module ctap_top (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [ctap_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ctap_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ctap_pkg::DATA_W-1:0] o_rdata
);
  import ctap_pkg::*;

  logic [CTL_W-1:0] ctl_q;
  logic [DATA_W-1:0] tag_q;
  logic [LINE_W-1:0] fill_buf_q;
  logic [LINE_W-1:0] flush_buf_q;
  logic [LINE_W-1:0] line_data_q [NUM_ENTRIES];
  logic [TAG_ADDR_W-1:0] tag_store_q [NUM_ENTRIES];
  logic [3:0] dirty_store_q [NUM_ENTRIES];
  logic [2:0] lru_q [NUM_LINES];
  logic [NUM_ENTRIES-1:0] valid_q;
  logic [DATA_W-1:0] rdata_q;

  logic wr_data;
  logic wr_tag;
  logic wr_ctl;
  logic [1:0] wr_code;
  logic [ENTRY_W-1:0] wr_entry;
  logic [7:0] wr_line;
  logic [1:0] wr_set;
  logic do_cwrite;
  logic do_cread;
  logic do_flush;
  logic [1:0] word_sel;
  logic [DATA_W-1:0] flush_word;
  logic [DATA_W-1:0] entry_tag_word;
  logic [LINE_W-1:0] entry_line;

  function automatic logic [DATA_W-1:0] word_of(input logic [LINE_W-1:0] buf_in,
                                                 input logic [1:0] sel);
    word_of = buf_in[sel*DATA_W +: DATA_W];
  endfunction

  // pseudo-lru after an access to the given set
  function automatic logic [2:0] lru_touch(input logic [2:0] old, input logic [1:0] set);
    logic [2:0] nxt;
    nxt = old;
    nxt[0] = ~set[1];
    if (set[1]) begin
      nxt[2] = ~set[0];
    end else begin
      nxt[1] = ~set[0];
    end
    lru_touch = nxt;
  endfunction

  assign wr_data = i_wr && (i_addr == DATA_ADDR);
  assign wr_tag = i_wr && (i_addr == TAG_ADDR);
  assign wr_ctl = i_wr && (i_addr == CTL_ADDR);
  assign wr_code = i_wdata[CTL_CODE_LSB +: 2];
  assign wr_set = i_wdata[CTL_SEL_LSB +: 2];
  assign wr_line = i_wdata[CTL_LINE_LSB +: 8];
  assign wr_entry = {wr_line, wr_set};
  // the operation fires on the control write itself
  assign do_cwrite = wr_ctl && (wr_code == CODE_CACHE_WRITE);
  assign do_cread = wr_ctl && (wr_code == CODE_CACHE_READ);
  assign do_flush = wr_ctl && (wr_code == CODE_CACHE_FLUSH);
  // word comes from the stored control value, so a data access may follow it at once
  assign word_sel = ctl_q[CTL_SEL_LSB +: 2];
  assign flush_word = word_of(flush_buf_q, word_sel);
  assign entry_line = line_data_q[wr_entry];
  assign entry_tag_word = {tag_store_q[wr_entry], 1'b0, valid_q[wr_entry], lru_q[wr_line],
                           dirty_store_q[wr_entry], 3'h0};

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctl_q <= CTL_RESET;
    end else if (wr_ctl) begin
      ctl_q <= i_wdata[CTL_W-1:0];
    end
  end

  // lru is write-ignored and reserved bits never stored
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      tag_q <= RESET_WORD;
    end else if (do_cread) begin
      tag_q <= entry_tag_word;
    end else if (wr_tag) begin
      // lru and reserved positions read back zero after a software write
      tag_q <= {i_wdata[TAG_ADDR_LSB +: TAG_ADDR_W], 1'b0, i_wdata[TAG_VALID_BIT], 3'h0,
                i_wdata[TAG_DIRTY_LSB +: 4], 3'h0};
    end
  end

  // each word is written alone; others hold so a line builds up
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_fill
      always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
          fill_buf_q[gw*DATA_W +: DATA_W] <= RESET_WORD;
        end else if (wr_data && (ctl_q[1:0] == CODE_BUFFER) && (word_sel == gw)) begin
          fill_buf_q[gw*DATA_W +: DATA_W] <= i_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      flush_buf_q <= RESET_LINE;
    end else if (do_cread) begin
      flush_buf_q <= entry_line;
    end
  end

  // data and tag arrays carry no reset; valid bits guard them
  always_ff @(posedge i_sys_clk) begin
    if (do_cwrite) begin
      line_data_q[wr_entry] <= fill_buf_q;
      tag_store_q[wr_entry] <= tag_q[TAG_ADDR_LSB +: TAG_ADDR_W];
      dirty_store_q[wr_entry] <= tag_q[TAG_DIRTY_LSB +: 4];
    end
  end

  // a test write counts as an access to its set for the replacement state
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        lru_q[i] <= LRU_RESET;
      end
    end else if (do_cwrite) begin
      lru_q[wr_line] <= lru_touch(lru_q[wr_line], wr_set);
    end
  end

  // flush and cache write never share a cycle: one strobe per cycle
  genvar ge;
  generate
    for (ge = 0; ge < NUM_ENTRIES; ge++) begin : g_valid
      always_ff @(posedge i_sys_clk) begin
        if (i_reset || do_flush) begin
          valid_q[ge] <= 1'b0;
        end else if (do_cwrite && (wr_entry == ge)) begin
          valid_q[ge] <= tag_q[TAG_VALID_BIT];
        end
      end
    end
  endgenerate

  // data read always means flush buffer; unmapped reads answer zero
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_rd) begin
      rdata_q <= RESET_WORD;
    end else begin
      case (i_addr)
        DATA_ADDR: rdata_q <= flush_word;
        TAG_ADDR: rdata_q <= tag_q;
        CTL_ADDR: rdata_q <= {20'h0, ctl_q};
        default: rdata_q <= RESET_WORD;
      endcase
    end
  end
  assign o_rdata = rdata_q;

  chk_fill_word_load: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data && ctl_q[1:0] == CODE_BUFFER |=> word_of(fill_buf_q, $past(word_sel)) == $past(i_wdata))
    else $error("fill word not loaded");

  chk_flush_word_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_rd && i_addr == DATA_ADDR |=> o_rdata == $past(flush_word))
    else $error("wrong flush word returned");

  chk_cache_write_line: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite |=> line_data_q[$past(wr_entry)] == $past(fill_buf_q))
    else $error("line not copied from fill buffer");

  chk_cache_write_tag: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite |=> tag_store_q[$past(wr_entry)] == $past(tag_q[31:12])
      && valid_q[$past(wr_entry)] == $past(tag_q[TAG_VALID_BIT])
      && dirty_store_q[$past(wr_entry)] == $past(tag_q[6:3]))
    else $error("entry state not taken from tag register");

  chk_cache_read_flush: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread |=> flush_buf_q == $past(entry_line))
    else $error("flush buffer not loaded from line");

  chk_tag_read_back: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread ##1 (i_rd && i_addr == TAG_ADDR && !i_wr) |=> o_rdata == $past(entry_tag_word, 2))
    else $error("tag register does not show read entry");

  chk_flush_all: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_flush |=> valid_q == '0)
    else $error("valid bits survive cache flush");

  chk_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    tag_q[2:0] == 3'h0 && tag_q[11] == 1'b0)
    else $error("reserved tag bits set");

  chk_lru_touch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite |=> lru_q[$past(wr_line)][0] == ~$past(wr_set[1]))
    else $error("lru half bit wrong after write");

  chk_buffers_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !wr_data && !do_cread |=> $stable(fill_buf_q) && $stable(flush_buf_q))
    else $error("buffer changed without access");

  chk_read_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !i_rd |=> o_rdata == RESET_WORD)
    else $error("read data outside answer cycle");

  // a software tag write stores the lru position as zero
  chk_tag_lru_drop: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_tag |=> tag_q[TAG_LRU_LSB +: 3] == 3'h0)
    else $error("lru bits kept from tag write");

  chk_tag_write_fields: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_tag |=> tag_q[31:12] == $past(i_wdata[31:12])
      && tag_q[TAG_VALID_BIT] == $past(i_wdata[10])
      && tag_q[6:3] == $past(i_wdata[6:3]))
    else $error("tag register write fields lost");

  chk_ctl_store: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_ctl |=> ctl_q == $past(i_wdata[11:0]))
    else $error("control value not stored");

  chk_ctl_read_back: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_rd && i_addr == CTL_ADDR |=> o_rdata == {20'h0, $past(ctl_q)})
    else $error("control register read back wrong");

  chk_fill_refused: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data && ctl_q[1:0] != CODE_BUFFER |=> $stable(fill_buf_q))
    else $error("fill buffer written outside buffer code");

  // only the addressed word moves; the next word up must hold
  chk_fill_neighbour: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data && ctl_q[1:0] == CODE_BUFFER
      |=> word_of(fill_buf_q, $past(word_sel) + 2'h1)
        == word_of($past(fill_buf_q), $past(word_sel) + 2'h1))
    else $error("fill write disturbed another word");

  chk_cread_state: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread |=> tag_q[31:12] == tag_store_q[$past(wr_entry)]
      && tag_q[TAG_VALID_BIT] == valid_q[$past(wr_entry)]
      && tag_q[9:7] == lru_q[$past(wr_line)])
    else $error("tag register misses entry state after read");

  chk_lru_low_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite && !wr_set[1] |=> lru_q[$past(wr_line)][1] == ~$past(wr_set[0]))
    else $error("lru pair bit wrong for sets 0 and 1");

  chk_lru_high_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite && wr_set[1] |=> lru_q[$past(wr_line)][2] == ~$past(wr_set[0]))
    else $error("lru pair bit wrong for sets 2 and 3");

  chk_cwrite_keeps_flush: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cwrite |=> $stable(flush_buf_q))
    else $error("cache write disturbed flush buffer");

  chk_cread_keeps_fill: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread |=> $stable(fill_buf_q))
    else $error("cache read disturbed fill buffer");

  chk_flush_only_valid: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    do_flush |=> $stable(tag_q) && $stable(flush_buf_q))
    else $error("cache flush touched more than valid bits");

  // valid bits move only on a cache write or a flush
  chk_valid_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !do_cwrite && !do_flush |=> $stable(valid_q))
    else $error("valid bits changed without an operation");

  chk_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_rd && i_addr != DATA_ADDR && i_addr != TAG_ADDR && i_addr != CTL_ADDR
      |=> o_rdata == RESET_WORD)
    else $error("unmapped read returned data");

  cov_refused_fill: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data && ctl_q[1:0] != CODE_BUFFER);
  cov_fill_then_write: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    wr_data ##[1:8] do_cwrite);
  cov_read_then_drain: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread ##[1:8] (i_rd && i_addr == DATA_ADDR));
  cov_flush: cover property (@(posedge i_sys_clk) disable iff (i_reset) do_flush);
  cov_tag_read: cover property (@(posedge i_sys_clk) disable iff (i_reset)
    do_cread ##1 (i_rd && i_addr == TAG_ADDR));
endmodule

// file: ctap_top_test.sv
// self-checking bench for the cache test access port
// assumes ctap_pkg and ctap_top are compiled first; drives the register port directly
`timescale 1ns/1ps
module ctap_top_test;
  import ctap_pkg::*;
  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] val;
  } ctap_row_type;
  localparam int NROWS = 36;
  // write rows carry data, read rows carry the expected read data
  localparam ctap_row_type ROWS [NROWS] = '{
    '{1'b0, CTL_ADDR, 32'h0}, '{1'b0, DATA_ADDR, 32'h1111_0000},
    '{1'b0, CTL_ADDR, 32'h4}, '{1'b0, DATA_ADDR, 32'h2222_0001},
    '{1'b0, CTL_ADDR, 32'h8}, '{1'b0, DATA_ADDR, 32'h3333_0002},
    '{1'b0, CTL_ADDR, 32'hc}, '{1'b0, DATA_ADDR, 32'h4444_0003},
    '{1'b0, TAG_ADDR, 32'habcd_e7d7}, '{1'b1, TAG_ADDR, 32'habcd_e450},
    '{1'b0, CTL_ADDR, 32'h129}, '{1'b0, CTL_ADDR, 32'h12a},
    '{1'b0, DATA_ADDR, 32'hdead_beef}, '{1'b1, TAG_ADDR, 32'habcd_e650},
    '{1'b0, CTL_ADDR, 32'h0}, '{1'b1, DATA_ADDR, 32'h1111_0000},
    '{1'b0, CTL_ADDR, 32'h4}, '{1'b1, DATA_ADDR, 32'h2222_0001},
    '{1'b0, CTL_ADDR, 32'h8}, '{1'b1, DATA_ADDR, 32'h3333_0002},
    '{1'b0, CTL_ADDR, 32'hc}, '{1'b1, DATA_ADDR, 32'h4444_0003},
    '{1'b0, TAG_ADDR, 32'h400}, '{1'b0, CTL_ADDR, 32'h1},
    '{1'b0, CTL_ADDR, 32'h2}, '{1'b1, TAG_ADDR, 32'h580},
    '{1'b0, CTL_ADDR, 32'h8}, '{1'b1, DATA_ADDR, 32'h3333_0002},
    '{1'b0, CTL_ADDR, 32'h3}, '{1'b0, CTL_ADDR, 32'h12a},
    '{1'b1, TAG_ADDR, 32'habcd_e250}, '{1'b1, CTL_ADDR, 32'h12a},
    '{1'b0, 8'h18, 32'hffff_ffff}, '{1'b1, 8'h18, 32'h0},
    '{1'b1, 8'h00, 32'h0}, '{1'b1, 8'h1c, 32'h0}
  };
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycle_cnt = 0;

  ctap_top ctap_top_i (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one strobe cycle, then an idle cycle in which a read's data stands
  task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_rd <= rd;
    i_wr <= ~rd;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    i_wr <= 1'b0;
    #1;
    if (rd) begin
      check(o_rdata, v);
    end else begin
      check(o_rdata, 32'h0);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run is well under 400 cycles; the ceiling leaves ample slack
  always @(posedge i_sys_clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    bus(1'b1, DATA_ADDR, 32'h0);
    bus(1'b1, TAG_ADDR, 32'h0);
    bus(1'b1, CTL_ADDR, 32'h0);
    for (int r = 0; r < NROWS; r++) begin
      bus(ROWS[r].rd, ROWS[r].addr, ROWS[r].val);
    end
    // second reset mid-run: valid and lru cleared, stored tag and dirty kept
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    bus(1'b1, CTL_ADDR, 32'h0);
    bus(1'b1, TAG_ADDR, 32'h0);
    bus(1'b0, CTL_ADDR, 32'h12a);
    bus(1'b1, TAG_ADDR, 32'habcd_e050);
    bus(1'b0, CTL_ADDR, 32'h8);
    bus(1'b1, DATA_ADDR, 32'h3333_0002);
    // back-to-back: control write then data read with no idle cycle between
    @(posedge i_sys_clk);
    i_addr <= CTL_ADDR;
    i_wdata <= 32'h4;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_addr <= DATA_ADDR;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, 32'h2222_0001);
    end_sim();
  end
endmodule
